// >>> rtl/dpc_pkg.sv
// Package for the drive and power configuration register bank
package dpc_pkg;

	// Register addresses carried by register access commands
	localparam logic [23:0] DPC_ADDR_NV   = 24'h000005;
	localparam logic [23:0] DPC_ADDR_LIVE = 24'h070005;

	// Field positions
	localparam int DPC_IMP_MSB   = 7;
	localparam int DPC_IMP_LSB   = 5;
	localparam int DPC_PDS_BIT   = 2;
	localparam int DPC_RSV1_BIT  = 3;

	// Factory default: impedance 000, startup power-down 0, bit 3 one
	localparam logic [2:0] DPC_IMP_RESET = 3'h0;
	localparam logic       DPC_PDS_RESET = 1'b0;
	localparam logic [7:0] DPC_REG_RESET = 8'h08;

	// Command kinds handed over by the command decoder
	typedef enum logic [1:0] {
		DPC_CMD_NONE  = 2'b00,
		DPC_CMD_WRITE = 2'b01,
		DPC_CMD_READ  = 2'b10,
		DPC_CMD_RDDED = 2'b11
	} dpc_cmd_t;

	// Power state machine
	typedef enum logic [1:0] {
		DPC_ST_STARTUP = 2'b00,
		DPC_ST_STANDBY = 2'b01,
		DPC_ST_DPD     = 2'b10,
		DPC_ST_EXIT    = 2'b11
	} dpc_state_t;

	// Timing
	localparam int DPC_CLK_PERIOD_NS = 40;
	localparam int DPC_T_CSDPD_NS    = 100;
	localparam int DPC_T_EXTDPD_NS   = 1000;
	localparam int DPC_CSDPD_CYC     = (DPC_T_CSDPD_NS + DPC_CLK_PERIOD_NS - 1) / DPC_CLK_PERIOD_NS;
	localparam int DPC_EXTDPD_CYC    = (DPC_T_EXTDPD_NS + DPC_CLK_PERIOD_NS - 1) / DPC_CLK_PERIOD_NS;
	localparam int DPC_CNT_W         = 16;

	// Typical impedance in ohms per select code
	localparam logic [6:0] DPC_OHM_45  = 7'h2D;
	localparam logic [6:0] DPC_OHM_120 = 7'h78;
	localparam logic [6:0] DPC_OHM_90  = 7'h5A;
	localparam logic [6:0] DPC_OHM_60  = 7'h3C;
	localparam logic [6:0] DPC_OHM_30  = 7'h1E;
	localparam logic [6:0] DPC_OHM_20  = 7'h14;

endpackage

// >>> rtl/dpc_drive_power_config.sv
// Drive impedance and startup power-down configuration register bank
//
// Function
// - Writes only by write-any-register; reads by dedicated read or read-any-register.
// - Write-any-register at address 000005 updates the non-volatile copy.
// - Write-any-register at address 070005 updates only the volatile copy.
// - Read-any-register answers at either address with register contents.
// - Factory default: impedance and bits 4,2,1,0 zero, bit 3 one.
// - Separate non-volatile and volatile copies, impedance and startup bit read/write.
// - Bits 7 to 5 select the output drive impedance of the pins.
// - Startup bit one: enter deep power-down after power-on or hardware reset, chip select high.
// - Startup bit zero: enter standby after power-on or hardware reset, chip select high.
// - Bits 4, 1 and 0 are reserved, read zero, no function.
// - Impedance codes map to 45,120,90,60,45,30,20,20 ohms.
// - Leave startup deep power-down on a long chip select pulse or hardware reset.
// - Software reset ignores the startup bit; hibernate exit obeys it.
`timescale 1ns/10ps
module dpc_drive_power_config
	import dpc_pkg::*;
#(
	parameter int CSDPD_CYC  = DPC_CSDPD_CYC,
	parameter int EXTDPD_CYC = DPC_EXTDPD_CYC
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        cmd_valid,
	input  wire dpc_cmd_t    cmd_kind,
	input  wire logic [23:0] cmd_addr,
	input  wire logic [7:0]  cmd_wdata,
	input  wire logic        cs_n,
	input  wire logic        hw_reset_done,
	input  wire logic        sw_reset_done,
	input  wire logic        hibernate_exit,
	output logic             rd_valid_ff,
	output logic [7:0]       rd_data_ff,
	output logic [2:0]       output_impedance_select_ff,
	output logic [6:0]       impedance_ohms_ff,
	output logic             deep_power_down_ff,
	output logic             standby_ff
);

	logic [1:0]           rst_sync_ff;
	logic                 rst_int_n;
	logic [2:0]           nv_imp_ff;
	logic                 nv_pds_ff;
	logic [2:0]           live_imp_ff;
	logic                 live_pds_ff;
	dpc_state_t           state_ff;
	dpc_state_t           nxt_state;
	logic                 use_pds_ff;
	logic                 nxt_use_pds;
	logic [DPC_CNT_W-1:0] cnt_ff;
	logic [DPC_CNT_W-1:0] nxt_cnt;
	logic                 cs_n_d_ff;
	logic [2:0]           nxt_live_imp;
	logic                 nxt_live_pds;
	logic [6:0]           nxt_ohms;

	// Reset release through two flops; the first stage feeds only the second
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_ff[1];

	// Command decode; commands are dropped while asleep in deep power-down
	wire awake      = (state_ff == DPC_ST_STANDBY);
	wire hit_nv     = (cmd_addr == DPC_ADDR_NV);
	wire hit_live   = (cmd_addr == DPC_ADDR_LIVE);
	wire wr_nv      = cmd_valid && awake && (cmd_kind == DPC_CMD_WRITE) && hit_nv;
	wire wr_live    = cmd_valid && awake && (cmd_kind == DPC_CMD_WRITE) && hit_live;
	wire rd_any_nv  = cmd_valid && awake && (cmd_kind == DPC_CMD_READ) && hit_nv;
	wire rd_any_lv  = cmd_valid && awake && (cmd_kind == DPC_CMD_READ) && hit_live;
	wire rd_ded     = cmd_valid && awake && (cmd_kind == DPC_CMD_RDDED);
	wire rd_any     = rd_any_nv || rd_any_lv || rd_ded;

	// Reserved bits are not stored: bit 3 always reads one, bits 4,1,0 zero
	wire [7:0] nv_view   = {nv_imp_ff, 1'b0, 1'b1, nv_pds_ff, 2'b00};
	wire [7:0] live_view = {live_imp_ff, 1'b0, 1'b1, live_pds_ff, 2'b00};
	wire [7:0] rd_mux    = rd_any_nv ? nv_view : live_view;

	// Reset reload of the active copy from the stored copy
	wire reload = hw_reset_done;

	// Non-volatile copy; flops stand in for the cell array, so it returns to factory value on power loss
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			nv_imp_ff <= DPC_IMP_RESET;
		end else if (wr_nv) begin
			nv_imp_ff <= cmd_wdata[DPC_IMP_MSB:DPC_IMP_LSB];
		end
	end

	// Stored startup bit
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			nv_pds_ff <= DPC_PDS_RESET;
		end else if (wr_nv) begin
			nv_pds_ff <= cmd_wdata[DPC_PDS_BIT];
		end
	end

	// Volatile copy next value
	always_comb begin
		nxt_live_imp = live_imp_ff;
		nxt_live_pds = live_pds_ff;
		if (reload) begin
			nxt_live_imp = nv_imp_ff;
			nxt_live_pds = nv_pds_ff;
		end else if (wr_live) begin
			nxt_live_imp = cmd_wdata[DPC_IMP_MSB:DPC_IMP_LSB];
			nxt_live_pds = cmd_wdata[DPC_PDS_BIT];
		end
	end

	// Power-on loads the factory value, which is also what the stored copy holds then
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			live_imp_ff <= DPC_IMP_RESET;
		end else begin
			live_imp_ff <= nxt_live_imp;
		end
	end

	// Active startup bit
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			live_pds_ff <= DPC_PDS_RESET;
		end else begin
			live_pds_ff <= nxt_live_pds;
		end
	end

	// Impedance decode
	always_comb begin
		case (nxt_live_imp)
			3'h0:    nxt_ohms = DPC_OHM_45;
			3'h1:    nxt_ohms = DPC_OHM_120;
			3'h2:    nxt_ohms = DPC_OHM_90;
			3'h3:    nxt_ohms = DPC_OHM_60;
			3'h4:    nxt_ohms = DPC_OHM_45;
			3'h5:    nxt_ohms = DPC_OHM_30;
			default: nxt_ohms = DPC_OHM_20;
		endcase
	end

	// Power state machine
	wire cs_rise   = cs_n && !cs_n_d_ff;
	wire pulse_ok  = (cnt_ff >= CSDPD_CYC[DPC_CNT_W-1:0]);
	wire exit_done = (cnt_ff >= EXTDPD_CYC[DPC_CNT_W-1:0]);

	always_comb begin
		nxt_state   = state_ff;
		nxt_use_pds = use_pds_ff;
		nxt_cnt     = cnt_ff;
		case (state_ff)
			DPC_ST_STARTUP: begin
				// Decision waits for chip select high
				if (cs_n) begin
					nxt_cnt = '0;
					if (use_pds_ff && live_pds_ff) begin
						nxt_state = DPC_ST_DPD;
					end else begin
						nxt_state = DPC_ST_STANDBY;
					end
				end
			end
			DPC_ST_STANDBY: begin
				if (hw_reset_done) begin
					nxt_state   = DPC_ST_STARTUP;
					nxt_use_pds = 1'b1;
				end else if (sw_reset_done) begin
					nxt_state   = DPC_ST_STARTUP;
					nxt_use_pds = 1'b0;
				end
			end
			DPC_ST_DPD: begin
				// Only chip select, hardware reset completion and hibernate exit are watched; clock and data lines play no part
				if (hw_reset_done) begin
					nxt_state = DPC_ST_EXIT;
					nxt_cnt   = '0;
				end else if (cs_rise && pulse_ok) begin
					nxt_state = DPC_ST_EXIT;
					nxt_cnt   = '0;
				end else if (!cs_n) begin
					nxt_cnt = (cnt_ff == '1) ? cnt_ff : cnt_ff + 1'b1;
				end else begin
					nxt_cnt = '0;
				end
			end
			default: begin
				if (exit_done) begin
					nxt_state = DPC_ST_STANDBY;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
		endcase
		// Hibernate exit follows the startup bit like a reset completion
		if (hibernate_exit) begin
			nxt_state   = DPC_ST_STARTUP;
			nxt_use_pds = 1'b1;
		end
	end

	// Power-on reset counts as a reset completion that obeys the startup bit
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			state_ff <= DPC_ST_STARTUP;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Startup bit is obeyed unless a software reset led here
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			use_pds_ff <= 1'b1;
		end else begin
			use_pds_ff <= nxt_use_pds;
		end
	end

	// Pulse width and exit delay share one counter
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Resets to the idle level of chip select, so no false rise follows reset
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			cs_n_d_ff <= 1'b1;
		end else begin
			cs_n_d_ff <= cs_n;
		end
	end

	// Next values of the registered outputs
	wire       nxt_dpd     = (nxt_state == DPC_ST_DPD);
	wire       nxt_standby = (nxt_state == DPC_ST_STANDBY);
	wire [7:0] nxt_rd_data = rd_any ? rd_mux : 8'h00;

	// Read answer strobe, one cycle per taken read
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= rd_any;
		end
	end

	// Read data stays zero between answers
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			rd_data_ff <= 8'h00;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	// Active impedance code
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			output_impedance_select_ff <= DPC_IMP_RESET;
		end else begin
			output_impedance_select_ff <= nxt_live_imp;
		end
	end

	// Typical impedance for the active code
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			impedance_ohms_ff <= DPC_OHM_45;
		end else begin
			impedance_ohms_ff <= nxt_ohms;
		end
	end

	// Power mode flags
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			deep_power_down_ff <= 1'b0;
		end else begin
			deep_power_down_ff <= nxt_dpd;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			standby_ff <= 1'b0;
		end else begin
			standby_ff <= nxt_standby;
		end
	end

endmodule // dpc_drive_power_config

// >>> dv/dpc_drive_power_config_sva.sv
// Assertion checker for the drive and power configuration bank
`timescale 1ns/10ps
module dpc_drive_power_config_sva
	import dpc_pkg::*;
#(
	parameter int CSDPD_CYC  = 3,
	parameter int EXTDPD_CYC = 25
) (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire dpc_cmd_t    cmd_kind,
	input wire logic [23:0] cmd_addr,
	input wire logic [7:0]  cmd_wdata,
	input wire logic        cs_n,
	input wire logic        hw_reset_done,
	input wire logic        sw_reset_done,
	input wire logic        hibernate_exit,
	input wire logic        rd_valid_ff,
	input wire logic [7:0]  rd_data_ff,
	input wire logic [2:0]  output_impedance_select_ff,
	input wire logic [6:0]  impedance_ohms_ff,
	input wire logic        deep_power_down_ff,
	input wire logic        standby_ff
);
	localparam int EXIT_MAX = EXTDPD_CYC + CSDPD_CYC + 8;
	localparam logic [6:0] OHM [8] = '{7'h2D, 7'h78, 7'h5A, 7'h3C, 7'h2D, 7'h1E, 7'h14, 7'h14};
	wire logic       tk     = cmd_valid && standby_ff && !hw_reset_done;
	// Reads are answered even while a hardware reset completes
	wire logic       rd_hit = cmd_valid && standby_ff && (cmd_kind == DPC_CMD_RDDED || (cmd_kind == DPC_CMD_READ
		&& (cmd_addr == DPC_ADDR_NV || cmd_addr == DPC_ADDR_LIVE)));
	wire logic       wr_lv  = tk && cmd_kind == DPC_CMD_WRITE && cmd_addr == DPC_ADDR_LIVE;
	wire logic       wr_nv  = tk && cmd_kind == DPC_CMD_WRITE && cmd_addr == DPC_ADDR_NV;
	wire logic [2:0] wr_imp = cmd_wdata[7:5];
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Four low samples so a design counting three or more still qualifies
	sequence cs_pulse_s; (deep_power_down_ff && !cs_n) [*4] ##1 (cs_n && !hibernate_exit); endsequence
	sequence sw_s;
		standby_ff && sw_reset_done && !hw_reset_done && !hibernate_exit ##1 cs_n && !hibernate_exit;
	endsequence
	rd_answer_a: assert property (rd_valid_ff == $past(rd_hit)) else $error("read answer wrong");
	rd_idle_a: assert property (!rd_valid_ff |-> rd_data_ff == 8'h00) else $error("idle data");
	rd_fixed_a: assert property (rd_valid_ff |-> rd_data_ff[4:3] == 2'b01 && rd_data_ff[1:0] == 2'b00)
		else $error("reserved bits wrong");
	live_write_a: assert property (wr_lv |=> output_impedance_select_ff == $past(wr_imp)) else $error("live write");
	nv_write_a: assert property (wr_nv |=> $stable(output_impedance_select_ff)) else $error("nv write");
	ohm_map_a: assert property (impedance_ohms_ff == OHM[output_impedance_select_ff]) else $error("ohms");
	flags_excl_a: assert property (!(deep_power_down_ff && standby_ff)) else $error("both flags");
	sw_standby_a: assert property (sw_s |=> standby_ff && !deep_power_down_ff) else $error("sw reset");
	dpd_exit_a: assert property (cs_pulse_s |=> !deep_power_down_ff ##[1:EXIT_MAX] standby_ff)
		else $error("dpd exit");
endmodule // dpc_drive_power_config_sva

bind dpc_drive_power_config dpc_drive_power_config_sva #(.CSDPD_CYC(CSDPD_CYC), .EXTDPD_CYC(EXTDPD_CYC)) sva_inst (
	.clk_sys, .rst_n, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_wdata, .cs_n, .hw_reset_done, .sw_reset_done,
	.hibernate_exit, .rd_valid_ff, .rd_data_ff, .output_impedance_select_ff, .impedance_ohms_ff,
	.deep_power_down_ff, .standby_ff);

// >>> dv/dpc_host_model.sv
// Behavioural host issuing register commands to the bank
`timescale 1ns/10ps
module dpc_host_model
	import dpc_pkg::*;
(
	input  wire logic   clk_sys,
	output logic        cmd_valid,
	output dpc_cmd_t    cmd_kind,
	output logic [23:0] cmd_addr,
	output logic [7:0]  cmd_wdata
);
	initial begin
		cmd_valid = 1'b0;
		cmd_kind = DPC_CMD_NONE;
		cmd_addr = 24'h0;
		cmd_wdata = 8'h0;
	end
	task automatic issue(input dpc_cmd_t k, input logic [23:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b1;
		cmd_kind = k;
		cmd_addr = a;
		cmd_wdata = d | 8'h08;
		@(posedge clk_sys);
		#1;
		cmd_valid = 1'b0;
		cmd_kind = DPC_CMD_NONE;
		// Released lines flip so a stale value is never mistaken for a live one
		cmd_addr = ~a;
		cmd_wdata = ~d;
	endtask
endmodule // dpc_host_model

// >>> dv/dpc_drive_power_config_tb_top.sv
// Self-checking bench for the drive and power configuration bank
`timescale 1ns/10ps
module dpc_drive_power_config_tb_top;
	import dpc_pkg::*;
	logic       clk_sys, rst_n, cs_n, hw_reset_done, sw_reset_done, hibernate_exit;
	logic       cmd_valid, rd_valid_ff, deep_power_down_ff, standby_ff;
	dpc_cmd_t   cmd_kind;
	logic [23:0] cmd_addr;
	logic [7:0] cmd_wdata, rd_data_ff;
	logic [2:0] output_impedance_select_ff;
	logic [6:0] impedance_ohms_ff;
	int         failures, check_count;
	dpc_host_model dpc_host_model_inst (.clk_sys, .cmd_valid, .cmd_kind, .cmd_addr, .cmd_wdata);
	dpc_drive_power_config #(.CSDPD_CYC(3), .EXTDPD_CYC(25)) dpc_drive_power_config_inst (.clk_sys, .rst_n,
		.cmd_valid, .cmd_kind, .cmd_addr, .cmd_wdata, .cs_n, .hw_reset_done, .sw_reset_done, .hibernate_exit,
		.rd_valid_ff, .rd_data_ff, .output_impedance_select_ff, .impedance_ohms_ff, .deep_power_down_ff, .standby_ff);
	task automatic chk(input string n, input logic [8:0] got, input logic [8:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", n, exp, got);
		end
	endtask
	task automatic rd(input dpc_cmd_t k, input logic [23:0] a, input logic [8:0] exp);
		dpc_host_model_inst.issue(k, a, 8'h00);
		chk("read", {rd_valid_ff, rd_data_ff}, exp);
	endtask
	task automatic wait_sb();
		for (int i = 0; i < 100 && standby_ff !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		chk("standby", {8'h00, standby_ff}, 9'h001);
	endtask
	task automatic pulse(ref logic s);
		@(posedge clk_sys);
		#1;
		s = 1'b1;
		@(posedge clk_sys);
		#1;
		s = 1'b0;
	endtask
	task automatic sc_regs();
		wait_sb();
		rd(DPC_CMD_RDDED, 24'h0, 9'h108);
		rd(DPC_CMD_READ, DPC_ADDR_NV, 9'h108);
		rd(DPC_CMD_READ, DPC_ADDR_LIVE, 9'h108);
		chk("ohms", {2'b00, impedance_ohms_ff}, 9'h02D);
	endtask
	task automatic sc_codes();
		logic [6:0] ohm [8] = '{7'h2D, 7'h78, 7'h5A, 7'h3C, 7'h2D, 7'h1E, 7'h14, 7'h14};
		for (int c = 0; c < 8; c++) begin
			dpc_host_model_inst.issue(DPC_CMD_WRITE, DPC_ADDR_LIVE, {c[2:0], 5'h1B});
			chk("select", {6'h00, output_impedance_select_ff}, {6'h00, c[2:0]});
			chk("ohms", {2'b00, impedance_ohms_ff}, {2'b00, ohm[c]});
			rd(DPC_CMD_READ, DPC_ADDR_LIVE, {1'b1, c[2:0], 5'h08});
		end
		dpc_host_model_inst.issue(DPC_CMD_WRITE, 24'h000006, 8'h20);
		rd(DPC_CMD_READ, 24'h000006, 9'h000);
		chk("select", {6'h00, output_impedance_select_ff}, 9'h007);
	endtask
	task automatic sc_power();
		dpc_host_model_inst.issue(DPC_CMD_WRITE, DPC_ADDR_NV, 8'hA4);
		chk("select", {6'h00, output_impedance_select_ff}, 9'h007);
		rd(DPC_CMD_READ, DPC_ADDR_NV, 9'h1AC);
		rd(DPC_CMD_READ, DPC_ADDR_LIVE, 9'h1E8);
		pulse(hw_reset_done);
		@(posedge clk_sys);
		#1;
		chk("dpd", {7'h00, deep_power_down_ff, standby_ff}, 9'h002);
		chk("select", {6'h00, output_impedance_select_ff}, 9'h005);
		rd(DPC_CMD_RDDED, 24'h0, 9'h000);
		cs_n = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		cs_n = 1'b1;
		wait_sb();
		pulse(sw_reset_done);
		@(posedge clk_sys);
		#1;
		chk("swrst", {7'h00, deep_power_down_ff, standby_ff}, 9'h001);
		pulse(hibernate_exit);
		@(posedge clk_sys);
		#1;
		chk("hib", {7'h00, deep_power_down_ff, standby_ff}, 9'h002);
		cs_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		cs_n = 1'b1;
		@(posedge clk_sys);
		#1;
		chk("short", {7'h00, deep_power_down_ff, standby_ff}, 9'h002);
		pulse(hw_reset_done);
		wait_sb();
		dpc_host_model_inst.issue(DPC_CMD_WRITE, DPC_ADDR_NV, 8'h08);
		pulse(hw_reset_done);
		@(posedge clk_sys);
		#1;
		chk("hwrst", {7'h00, deep_power_down_ff, standby_ff}, 9'h001);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// Whole run needs under two hundred cycles; this leaves wide margin
	initial begin
		#200000;
		failures++;
		tally_and_finish();
	end
	initial begin
		{rst_n, hw_reset_done, sw_reset_done, hibernate_exit} = 4'h0;
		cs_n = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		sc_regs();
		sc_codes();
		sc_power();
		tally_and_finish();
	end
endmodule // dpc_drive_power_config_tb_top
